// >>> hdl/acc_adc_conversion_control.sv
// Notes on behaviour
// - Writing one to the start bit begins a conversion.
// - A started conversion measures the selected channel and stores a 12-bit result.
// - In single conversion mode, hardware clears the start bit when the result is ready; continuous mode leaves it set.
// - Every result update sets the interrupt status bit; irq rises only while its mask bit is set.
// - Conversion clock is the input clock over 32 times (divider field plus one), field in bits 5:0.
// - Control bit 6 set gives continuous mode, clear gives single conversion.
// - Channel select in bits 11:8 is double buffered against changes mid conversion.
// - The working channel is loaded at start or while idle.
// - In continuous mode the working channel is reloaded at the end of each conversion.
// - Channel codes E,C,A,8,7,6,5,4,2,0 map to aux0, aux1, half supply, reference, aux3, clock supply,
//   aux2, aux5, aux4, aux6.
// - The result is unsigned binary proportional to input over twice the reference.
// - Input at twice the reference yields code 0x0fff.
// - Conversion rates up to one hundred thousand samples per second are supported.
`timescale 1ns/1ps
module acc_adc_conversion_control #(
  parameter int RES_W = acc_pkg::RES_W
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [acc_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic comp_in,
  output logic [RES_W-1:0] dac_code,
  output logic [acc_pkg::SEL_W-1:0] mux_select,
  output logic [acc_pkg::ANALOG_INPUTS-1:0] mux_onehot,
  output logic sample_hold,
  output logic irq
);
  import acc_pkg::*;
  initial begin
    if (RES_W != acc_pkg::RES_W) $error("acc_adc_conversion_control: result width must be 12");
  end
  typedef struct packed {
    logic [CTL_W-1:0] ctl;
    logic [SEL_W-1:0] chan;
    logic [RES_W-1:0] result;
    logic [IRQ_W-1:0] status;
    logic [IRQ_W-1:0] mask;
    logic ack;
    logic err;
    logic [31:0] rdata;
    logic [SEL_W-1:0] mux_sel;
    logic [ANALOG_INPUTS-1:0] mux_oh;
  } acc_top_st_t;
  acc_top_st_t st_ff, nxt_st;
  logic tick;
  logic busy;
  logic done;
  logic start_core;
  logic [RES_W-1:0] core_value;
  logic req;
  logic wr;
  logic hit_ctl;
  logic [ANALOG_INPUTS-1:0] oh;
  // Channel decode table, one entry per documented code
  localparam logic [SEL_W-1:0] CH_TAB [ANALOG_INPUTS] = '{CH_AUX0, CH_AUX1, CH_HALF_HIGH, CH_REF_NODE,
    CH_AUX3, CH_CLK_SUPPLY, CH_AUX2, CH_AUX5, CH_AUX4, CH_AUX6};
  // ----------------------------------------
  // Channel mux decode
  // ----------------------------------------
  // Undocumented codes select nothing; software must avoid them
  genvar gi;
  generate
    for (gi = 0; gi < ANALOG_INPUTS; gi++) begin : g_mux
      assign oh[gi] = (st_ff.chan == CH_TAB[gi]);
    end
  endgenerate
  // ----------------------------------------
  // Conversion clock and SAR core
  // ----------------------------------------
  // At 200 MHz the fastest rate is far above 0.1 Msps; the divider slows it
  acc_clk_div #(
    .DIV_W(DIV_W),
    .PRESCALE(PRESCALE)
  ) u_div (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .run(busy),
    .divider(st_ff.ctl[DIV_LSB +: DIV_W]),
    .tick(tick)
  );
  acc_sar_core #(
    .RES_W(RES_W)
  ) u_core (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .start(start_core),
    .tick(tick),
    .comp_in(comp_in),
    .dac_code(dac_code),
    .busy(busy),
    .done(done),
    .value(core_value)
  );
  // Core idles one cycle after done, so the working channel settles first
  assign start_core = st_ff.ctl[START_BIT] && !busy && !done;
  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  assign req = wb_cyc_i && wb_stb_i && !st_ff.ack && !st_ff.err;
  assign wr = req && wb_we_i;
  assign hit_ctl = wr && (wb_adr_i == ADR_CONTROL);
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ack = 1'b0;
    nxt_st.err = 1'b0;
    nxt_st.mux_sel = st_ff.chan;
    nxt_st.mux_oh = oh;
    // Register writes
    if (hit_ctl) begin
      if (wb_sel_i[0]) begin
        nxt_st.ctl[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        nxt_st.ctl[CTL_W-1:8] = wb_dat_i[CTL_W-1:8];
      end
    end
    if (wr && (wb_adr_i == ADR_IRQ_MASK) && wb_sel_i[0]) begin
      nxt_st.mask = wb_dat_i[IRQ_W-1:0];
    end
    if (wr && (wb_adr_i == ADR_IRQ_STATUS) && wb_sel_i[0]) begin
      nxt_st.status = st_ff.status & ~wb_dat_i[IRQ_W-1:0];
    end
    // Working channel: loaded when idle or at start
    if (!busy && !done) begin
      nxt_st.chan = st_ff.ctl[SEL_LSB +: SEL_W];
    end
    // Conversion end
    if (done) begin
      nxt_st.result = core_value;
      nxt_st.status[IRQ_DONE] = 1'b1;
      if (st_ff.ctl[MODE_BIT]) begin
        nxt_st.chan = st_ff.ctl[SEL_LSB +: SEL_W];
      end else if (!(hit_ctl && wb_sel_i[0] && wb_dat_i[START_BIT])) begin
        nxt_st.ctl[START_BIT] = 1'b0;
      end
    end
    // Single-shot chosen mid-run ends the sequence after this conversion
    if (done && !nxt_st.ctl[MODE_BIT] && st_ff.ctl[MODE_BIT]) begin
      nxt_st.ctl[START_BIT] = 1'b0;
    end
    // Answer
    if (req) begin
      nxt_st.rdata = '0;
      unique case (wb_adr_i)
        ADR_RESULT: begin
          nxt_st.ack = 1'b1;
          nxt_st.rdata[RES_W-1:0] = st_ff.result;
        end
        ADR_CONTROL: begin
          nxt_st.ack = 1'b1;
          nxt_st.rdata[CTL_W-1:0] = st_ff.ctl;
        end
        ADR_IRQ_STATUS: begin
          nxt_st.ack = 1'b1;
          nxt_st.rdata[IRQ_W-1:0] = st_ff.status;
        end
        ADR_IRQ_MASK: begin
          nxt_st.ack = 1'b1;
          nxt_st.rdata[IRQ_W-1:0] = st_ff.mask;
        end
        default: begin
          nxt_st.err = 1'b1;
        end
      endcase
    end
  end
  assign wb_dat_o = st_ff.rdata;
  assign wb_ack_o = st_ff.ack;
  assign wb_err_o = st_ff.err;
  assign mux_select = st_ff.mux_sel;
  assign mux_onehot = st_ff.mux_oh;
  assign sample_hold = busy;
  assign irq = |(st_ff.status & st_ff.mask);
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_ff <= '0;
      st_ff.ctl <= CTL_RESET;
      st_ff.result <= RES_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule : acc_adc_conversion_control

// >>> hdl/acc_clk_div.sv
`timescale 1ns/1ps
module acc_clk_div #(
  parameter int DIV_W = acc_pkg::DIV_W,
  parameter int PRESCALE = acc_pkg::PRESCALE
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic [DIV_W-1:0] divider,
  output logic tick
);
  import acc_pkg::*;
  localparam int CNT_W = DIV_W + $clog2(PRESCALE) + 1;
  initial begin
    if (PRESCALE < 2) $error("acc_clk_div: prescale too small");
  end
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } acc_div_st_t;
  acc_div_st_t st_ff, nxt_st;
  logic [CNT_W-1:0] limit;
  // ----------------------------------------
  // Period is prescale times (divider plus one)
  // ----------------------------------------
  always_comb begin
    limit = CNT_W'(PRESCALE * (int'(divider) + 1) - 1);
    nxt_st = st_ff;
    tick = 1'b0;
    if (!run) begin
      nxt_st.cnt = '0;
    end else if (st_ff.cnt >= limit) begin
      nxt_st.cnt = '0;
      tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + CNT_W'(1);
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule : acc_clk_div

// >>> hdl/acc_pkg.sv
package acc_pkg;
  // ----------------------------------------
  // Register map (printed offsets are word indices)
  // ----------------------------------------
  localparam logic [15:0] IDX_CONVERSION_RESULT = 16'hfecd;
  localparam logic [15:0] IDX_CONVERTER_CONTROL = 16'hfed6;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'hfed7;
  localparam logic [15:0] IDX_IRQ_MASK = 16'hfed8;
  localparam int ADR_W = 18;
  localparam logic [ADR_W-1:0] ADR_RESULT = {IDX_CONVERSION_RESULT, 2'b00};
  localparam logic [ADR_W-1:0] ADR_CONTROL = {IDX_CONVERTER_CONTROL, 2'b00};
  localparam logic [ADR_W-1:0] ADR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [ADR_W-1:0] ADR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};
  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  localparam int CTL_W = 12;
  localparam int RES_W = 12;
  localparam int DIV_LSB = 0;
  localparam int DIV_W = 6;
  localparam int MODE_BIT = 6;
  localparam int START_BIT = 7;
  localparam int SEL_LSB = 8;
  localparam int SEL_W = 4;
  localparam logic [CTL_W-1:0] CTL_RESET = 12'h03f;
  localparam logic [RES_W-1:0] RES_RESET = 12'h000;
  localparam logic [RES_W-1:0] RES_FULL_SCALE = 12'h0fff;
  localparam int PRESCALE = 32;
  localparam int BITS_PER_CONV = 12;
  // ----------------------------------------
  // Channel codes
  // ----------------------------------------
  localparam logic [SEL_W-1:0] CH_AUX0 = 4'he;
  localparam logic [SEL_W-1:0] CH_AUX1 = 4'hc;
  localparam logic [SEL_W-1:0] CH_HALF_HIGH = 4'ha;
  localparam logic [SEL_W-1:0] CH_REF_NODE = 4'h8;
  localparam logic [SEL_W-1:0] CH_AUX3 = 4'h7;
  localparam logic [SEL_W-1:0] CH_CLK_SUPPLY = 4'h6;
  localparam logic [SEL_W-1:0] CH_AUX2 = 4'h5;
  localparam logic [SEL_W-1:0] CH_AUX5 = 4'h4;
  localparam logic [SEL_W-1:0] CH_AUX4 = 4'h2;
  localparam logic [SEL_W-1:0] CH_AUX6 = 4'h0;
  localparam int ANALOG_INPUTS = 10;
  // ----------------------------------------
  // Interrupt bits
  // ----------------------------------------
  localparam int IRQ_W = 1;
  localparam int IRQ_DONE = 0;
  typedef enum logic [1:0] {ACC_IDLE, ACC_SAMPLE, ACC_DONE} acc_state_t;
endpackage : acc_pkg

// >>> hdl/acc_sar_core.sv
`timescale 1ns/1ps
module acc_sar_core #(
  parameter int RES_W = acc_pkg::RES_W
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic tick,
  input wire logic comp_in,
  output logic [RES_W-1:0] dac_code,
  output logic busy,
  output logic done,
  output logic [RES_W-1:0] value
);
  import acc_pkg::*;
  initial begin
    if (RES_W < 2) $error("acc_sar_core: width too small");
  end
  typedef struct packed {
    logic busy;
    logic [RES_W-1:0] trial;
    logic [RES_W-1:0] bit_mask;
    logic [RES_W-1:0] value;
    logic done;
  } acc_sar_st_t;
  acc_sar_st_t st_ff, nxt_st;
  // ----------------------------------------
  // Binary search, one bit per conversion clock
  // ----------------------------------------
  // Comparator high means input above trial voltage (scale 2 x reference)
  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    if (!st_ff.busy) begin
      if (start) begin
        nxt_st.busy = 1'b1;
        nxt_st.bit_mask = {1'b1, {(RES_W-1){1'b0}}};
        nxt_st.trial = {1'b1, {(RES_W-1){1'b0}}};
      end
    end else if (tick) begin
      if (!comp_in) begin
        nxt_st.trial = st_ff.trial & ~st_ff.bit_mask;
      end
      nxt_st.bit_mask = st_ff.bit_mask >> 1;
      nxt_st.trial = nxt_st.trial | (st_ff.bit_mask >> 1);
      if (st_ff.bit_mask[0]) begin
        nxt_st.busy = 1'b0;
        nxt_st.done = 1'b1;
        nxt_st.value = comp_in ? st_ff.trial : (st_ff.trial & ~st_ff.bit_mask);
      end
    end
  end
  assign dac_code = st_ff.trial;
  assign busy = st_ff.busy;
  assign done = st_ff.done;
  assign value = st_ff.value;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule : acc_sar_core

// >>> sim/acc_analog_model.sv
`timescale 1ns/1ps
module acc_analog_model (
  input wire logic [3:0] mux_select,
  input wire logic [11:0] dac_code,
  input wire logic [11:0] level [16],
  output logic comp_in
);
  // Reference taken as enabled and powered before any start
  // Ideal comparator, input code against trial code; no offset modelled
  assign comp_in = level[mux_select] >= dac_code;
endmodule : acc_analog_model

// >>> sim/acc_sva.sv
`timescale 1ns/1ps
module acc_sva (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [acc_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic [acc_pkg::SEL_W-1:0] mux_select,
  input wire logic [acc_pkg::ANALOG_INPUTS-1:0] mux_onehot,
  input wire logic sample_hold
);
  import acc_pkg::*;
  int busy_cnt_ff;
  logic mapped;
  assign mapped = wb_adr_i inside {ADR_RESULT, ADR_CONTROL, ADR_IRQ_STATUS, ADR_IRQ_MASK};
  // Table order, bit 0 is the first listed code
  logic [ANALOG_INPUTS-1:0] exp_oh;
  assign exp_oh = {mux_select == CH_AUX6, mux_select == CH_AUX4, mux_select == CH_AUX5, mux_select == CH_AUX2,
    mux_select == CH_CLK_SUPPLY, mux_select == CH_AUX3, mux_select == CH_REF_NODE, mux_select == CH_HALF_HIGH,
    mux_select == CH_AUX1, mux_select == CH_AUX0};
  // Busy length, so the 12 periods can be bounded
  always_ff @(posedge clk_sys) begin
    busy_cnt_ff <= (sys_rst || !sample_hold) ? 0 : busy_cnt_ff + 1;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  sequence s_answer;
    (wb_ack_o || wb_err_o) ##1 !(wb_ack_o || wb_err_o);
  endsequence
  property p_answer;
    s_req |=> s_answer;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer late or long");
  property p_err_unmapped;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && !mapped |=> wb_err_o && !wb_ack_o;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped not refused");
  property p_ack_mapped;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && mapped |=> wb_ack_o && !wb_err_o;
  endproperty
  a_ack_mapped: assert property (p_ack_mapped) else $error("mapped access not acked");
  property p_ack_cause;
    $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_mux_hold;
    busy_cnt_ff >= 2 && busy_cnt_ff <= 300 |-> $stable(mux_select);
  endproperty
  a_mux_hold: assert property (p_mux_hold) else $error("channel changed mid conversion");
  property p_onehot;
    $onehot0(mux_onehot);
  endproperty
  a_onehot: assert property (p_onehot) else $error("channel decode not one-hot");
  // Reset values of the pair are not a decode, so the first edge is skipped
  property p_onehot_map;
    !$past(sys_rst) |-> mux_onehot == exp_oh;
  endproperty
  a_onehot_map: assert property (p_onehot_map) else $error("channel decode wrong");
  property p_conv_min;
    $fell(sample_hold) |-> busy_cnt_ff >= 352;
  endproperty
  a_conv_min: assert property (p_conv_min) else $error("conversion too short");
  property p_conv_max;
    sample_hold |-> busy_cnt_ff <= 24600;
  endproperty
  a_conv_max: assert property (p_conv_max) else $error("conversion too long");
  property p_err_pulse;
    wb_err_o |=> !wb_err_o;
  endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("err longer than a cycle");
endmodule : acc_sva
bind acc_adc_conversion_control acc_sva i_acc_sva (.clk_sys, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_adr_i,
  .wb_ack_o, .wb_err_o, .mux_select, .mux_onehot, .sample_hold);

// >>> sim/test_adc_conversion_control.sv
`timescale 1ns/1ps
module test_adc_conversion_control;
  import acc_pkg::*;
  logic clk_sys, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, comp_in, sample_hold, irq, e;
  logic [ADR_W-1:0] wb_adr_i;
  logic [3:0] wb_sel_i, mux_select;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [11:0] dac_code;
  logic [11:0] level [16];
  int n_errors = 0;
  int check_count = 0;
  int cyc_n = 0;
  int c;
  acc_adc_conversion_control i_acc_adc_conversion_control (.clk_sys, .sys_rst, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .comp_in, .dac_code,
    .mux_select, .mux_onehot(), .sample_hold, .irq);
  acc_analog_model i_acc_analog_model (.mux_select, .dac_code, .level, .comp_in);
  initial begin
    clk_sys = 0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Whole run is near 4000 cycles
  always @(posedge clk_sys) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  task print_verdict();
    if (n_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task bus(input logic w, input logic [ADR_W-1:0] a, input logic [3:0] s, input logic [31:0] d);
    @(posedge clk_sys);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    // No wait-state count assumed; only the global timeout ends a hang
    do begin
      @(posedge clk_sys);
    end while (wb_ack_o !== 1 && wb_err_o !== 1);
    q = wb_dat_o;
    e = wb_err_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask : bus
  task wr(input logic [ADR_W-1:0] a, input logic [31:0] d);
    bus(1, a, 4'hf, d);
  endtask : wr
  task rd(input logic [ADR_W-1:0] a);
    bus(0, a, 4'hf, 32'h0000_0000);
  endtask : rd
  task wirq(input int lim);
    c = 0;
    while (irq !== 1 && c < lim) begin
      @(posedge clk_sys);
      c++;
    end
    if (irq !== 1) begin
      n_errors++;
    end
  endtask : wirq
  initial begin
    sys_rst = 1;
    wb_cyc_i = 0;
    wb_stb_i = 0;
    wb_we_i = 0;
    wb_adr_i = '0;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0000_0000;
    foreach (level[i]) level[i] = 12'h555;
    // Only listed channel codes are used
    level[14] = 12'hfff;
    level[12] = 12'h123;
    level[5] = 12'h000;
    level[4] = 12'ha5c;
    level[2] = 12'h801;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 0;
    rd(ADR_RESULT); chk(q, 32'h0000_0000);
    rd(ADR_CONTROL); chk(q, 32'h0000_003f);
    rd(ADR_IRQ_MASK); chk(q, 32'h0000_0000);
    rd(18'h0_0010); chk(e, 1);
    wr(ADR_IRQ_MASK, 32'h0000_0001);
    wr(ADR_CONTROL, 32'h0000_0e80);
    wirq(2000);
    rd(ADR_RESULT); chk(q, 32'h0000_0fff);
    rd(ADR_CONTROL); chk(q, 32'h0000_0e00);
    wr(ADR_IRQ_STATUS, 32'h0000_0001);
    rd(ADR_IRQ_STATUS); chk(q, 32'h0000_0000);
    chk(irq, 0);
    wr(ADR_CONTROL, 32'h0000_0c81);
    bus(1, ADR_CONTROL, 4'h2, 32'h0000_0500);
    wirq(2000);
    chk(c >= 700 && c <= 780, 1);
    rd(ADR_RESULT); chk(q, 32'h0000_0123);
    chk(mux_select, 4'h5);
    wr(ADR_IRQ_STATUS, 32'h0000_0001);
    wr(ADR_CONTROL, 32'h0000_04c0);
    wirq(2000);
    wr(ADR_IRQ_STATUS, 32'h0000_0001);
    bus(1, ADR_CONTROL, 4'h2, 32'h0000_0200);
    wirq(2000);
    rd(ADR_RESULT); chk(q, 32'h0000_0a5c);
    wr(ADR_IRQ_STATUS, 32'h0000_0001);
    wirq(2000);
    rd(ADR_RESULT); chk(q, 32'h0000_0801);
    // Masked: event is kept in status only
    wr(ADR_IRQ_MASK, 32'h0000_0000);
    wr(ADR_CONTROL, 32'h0000_0280);
    wr(ADR_IRQ_STATUS, 32'h0000_0001);
    repeat (1500) @(posedge clk_sys);
    chk(irq, 0);
    rd(ADR_CONTROL); chk(q, 32'h0000_0200);
    rd(ADR_IRQ_STATUS); chk(q, 32'h0000_0001);
    wr(ADR_IRQ_MASK, 32'h0000_0001);
    rd(ADR_RESULT); chk(q, 32'h0000_0801);
    chk(irq, 1);
    print_verdict();
  end
endmodule : test_adc_conversion_control
